// [dsa_pkg.sv]
package dsa_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 10;
    localparam int EXT_W = 24;
    localparam logic [15:0] SFR_LAST = 16'h0FFF;
    localparam logic [15:0] NEAR_LAST = 16'h1FFF;
    localparam logic [15:0] MEM_LAST = 16'hCFFF;
    localparam int WORD_DEPTH = 26624;
    localparam int NEAR_W = 13;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [9:0] PAGE_RST = 10'h001;
    localparam logic [15:0] DATA_RST = 16'h0000;
    typedef enum logic [2:0]
    {
        DSA_OP_NONE = 3'b001,
        DSA_OP_SE = 3'b010,
        DSA_OP_ZE = 3'b100
    } dsa_ext_t;
endpackage

// [dsa_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1: separate read and write address generation units form independent addresses.
// RL2: effective addresses are 16-bit byte addresses, 64 Kbyte, 32K words.
// RL3: read page extends reads, write page extends writes, to 16 Mbytes.
// RL4: memory spans 52 Kbytes; outside accesses return zero.
// RL5: low byte at even address, high byte at odd address.
// RL6: post-increment advances pointer by 1 for bytes, 2 for words.
// RL7: byte read fetches word, selects by bit 0, returns on low byte.
// RL8: byte write updates only the matching lane; shared word decode.
// RL9: word access at odd address raises address error trap.
// RL10: misaligned read lets the instruction complete before trap.
// RL11: misaligned write executes but memory write is suppressed.
// RL12: byte load into working register keeps its high byte.
// RL13: sign extend turns 8-bit signed into 16-bit signed.
// RL14: zero extend clears working register high byte.
// RL15: 0x0000-0x0FFF is register space; unused reads are zero.
// RL16: 0x0000-0x1FFF reachable by 13-bit direct address; the code offers this on the read port only (rd_near).
// RL17: lane enables from address bit 0 and size; none for faulting write.
// RL18: address error is a one-cycle pulse for odd word accesses.
module dsa_unit
    import dsa_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // read port
    input wire logic rd_req,
    input wire logic rd_byte,
    input wire logic rd_near,
    input wire logic [NEAR_W-1:0] rd_near_addr,
    input wire logic [ADDR_W-1:0] rd_ptr,
    input wire logic rd_postinc,
    input wire logic [DATA_W-1:0] rd_wreg_old,
    input wire dsa_ext_t rd_ext_op,
    output logic rd_valid_r,
    output logic [DATA_W-1:0] rd_data_r,
    output logic [DATA_W-1:0] rd_wreg_r,
    output logic [ADDR_W-1:0] rd_ptr_next_r,
    output logic [EXT_W-1:0] rd_ext_addr_r,
    // write port
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic [ADDR_W-1:0] wr_ptr,
    input wire logic wr_postinc,
    input wire logic [DATA_W-1:0] wr_data,
    output logic wr_done_r,
    output logic [ADDR_W-1:0] wr_ptr_next_r,
    output logic [EXT_W-1:0] wr_ext_addr_r,
    // page registers
    input wire logic rd_page_we,
    input wire logic wr_page_we,
    input wire logic [PAGE_W-1:0] page_wdata,
    output logic [PAGE_W-1:0] read_page_register_r,
    output logic [PAGE_W-1:0] write_page_register_r,
    // sfr window and trap
    input wire logic [DATA_W-1:0] sfr_rdata,
    output logic sfr_wr_r,
    output logic [1:0] sfr_lane_r,
    output logic [ADDR_W-1:0] sfr_addr_r,
    output logic [DATA_W-1:0] sfr_wdata_r,
    output logic addr_err_r
);
    wire logic [DATA_W-1:0] rd_mem;
    logic [ADDR_W-1:0] rd_ea;
    logic [ADDR_W-1:0] wr_ea;
    logic rd_mis;
    logic wr_mis;
    logic rd_in;
    logic wr_in;
    logic [1:0] wr_lane;
    logic [14:0] rd_word;
    logic [14:0] wr_word;
    logic [DATA_W-1:0] rd_raw;
    logic [7:0] rd_sel;
    logic [DATA_W-1:0] rd_val;

    // near addresses zero-extend from the 13-bit field
    assign rd_ea = rd_near ? {3'h0, rd_near_addr} : rd_ptr; // [RL16] [RL2]
    assign wr_ea = wr_ptr; // [RL1]
    assign rd_mis = rd_req && !rd_byte && rd_ea[0]; // [RL9]
    assign wr_mis = wr_req && !wr_byte && wr_ea[0]; // [RL9]
    assign rd_in = rd_ea <= MEM_LAST; // [RL4]
    assign wr_in = wr_ea <= MEM_LAST; // [RL4]
    assign rd_word = rd_ea[15:1];
    assign wr_word = wr_ea[15:1];

    always_comb
    begin
        // lane 0 is the even byte, lane 1 the odd byte
        if (!wr_req || wr_mis || !wr_in)
            wr_lane = 2'h0; // [RL11] [RL17]
        else if (wr_byte)
            wr_lane = wr_ea[0] ? 2'h2 : 2'h1; // [RL8] [RL5] [RL17]
        else
            wr_lane = 2'h3; // [RL17]
    end

    always_comb
    begin
        // unused register space is assumed to come back zero from sfr_rdata
        if (!rd_in)
            rd_raw = DATA_RST; // [RL4]
        else if (rd_ea <= SFR_LAST)
            rd_raw = sfr_rdata; // [RL15]
        else
            rd_raw = rd_mem;
        rd_sel = rd_ea[0] ? rd_raw[15:8] : rd_raw[7:0]; // [RL7] [RL5]
        rd_val = rd_byte ? {8'h00, rd_sel} : rd_raw; // [RL7]
    end

    // ram write, one enable per lane over a shared word decode
    generate
        for (genvar ln = 0; ln < 2; ln++)
        begin : g_lane
            // one array per lane keeps every array under a single writer
            logic [7:0] lane_mem [WORD_DEPTH];
            always_ff @(posedge clk_sys)
            begin
                if (wr_lane[ln] && wr_ea > SFR_LAST)
                    lane_mem[wr_word] <= wr_data[ln*8 +: 8]; // [RL8]
            end
            assign rd_mem[ln*8 +: 8] = lane_mem[rd_word]; // [RL8]
        end
    endgenerate

    // read address unit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r <= DATA_RST;
            rd_wreg_r <= DATA_RST;
            rd_ptr_next_r <= DATA_RST;
            rd_ext_addr_r <= '0;
        end
        else
        begin
            // misaligned read still completes; trap comes alongside
            rd_valid_r <= rd_req; // [RL10]
            if (rd_req)
            begin
                rd_data_r <= rd_val;
                rd_ext_addr_r <= {read_page_register_r[PAGE_W-2:0], rd_ea[14:0]}; // [RL3]
                rd_ptr_next_r <= rd_postinc ? rd_ptr + (rd_byte ? STEP_BYTE : STEP_WORD)
                                            : rd_ptr; // [RL6]
                case (rd_ext_op)
                    DSA_OP_SE: rd_wreg_r <= {{8{rd_val[7]}}, rd_val[7:0]}; // [RL13]
                    DSA_OP_ZE: rd_wreg_r <= {8'h00, rd_val[7:0]}; // [RL14]
                    DSA_OP_NONE: rd_wreg_r <= rd_byte ? {rd_wreg_old[15:8], rd_val[7:0]}
                                                     : rd_val; // [RL12]
                    default: rd_wreg_r <= rd_val;
                endcase
            end
        end
    end

    // write address unit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_done_r <= 1'b0;
            wr_ptr_next_r <= DATA_RST;
            wr_ext_addr_r <= '0;
            sfr_wr_r <= 1'b0;
            sfr_lane_r <= 2'h0;
            sfr_addr_r <= DATA_RST;
            sfr_wdata_r <= DATA_RST;
        end
        else
        begin
            wr_done_r <= wr_req; // [RL11]
            sfr_wr_r <= (wr_lane != 2'h0) && wr_ea <= SFR_LAST;
            sfr_lane_r <= wr_lane;
            if (wr_req)
            begin
                sfr_addr_r <= {wr_ea[15:1], 1'b0};
                sfr_wdata_r <= wr_data;
                wr_ext_addr_r <= {write_page_register_r[PAGE_W-2:0], wr_ea[14:0]}; // [RL3]
                wr_ptr_next_r <= wr_postinc ? wr_ptr + (wr_byte ? STEP_BYTE : STEP_WORD)
                                            : wr_ptr; // [RL6]
            end
        end
    end

    // page registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            read_page_register_r <= PAGE_RST;
            write_page_register_r <= PAGE_RST;
        end
        else
        begin
            if (rd_page_we)
                read_page_register_r <= page_wdata; // [RL3]
            if (wr_page_we)
                write_page_register_r <= page_wdata; // [RL3]
        end
    end

    // trap pulse, one cycle for each cycle holding a faulting read or write
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            addr_err_r <= 1'b0;
        else
            addr_err_r <= rd_mis || wr_mis; // [RL18] [RL9]
    end

    a_trap_pulse: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
        (rd_mis || wr_mis) |=> addr_err_r)
        else $error("misaligned access gave no trap");
    a_trap_cause: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
        addr_err_r |-> $past(rd_mis || wr_mis))
        else $error("trap without misaligned access");
    a_wr_suppress: assert property (@(posedge clk_sys) disable iff (rst) // [RL11]
        wr_mis |=> !sfr_wr_r && wr_done_r)
        else $error("faulting write not suppressed");
    a_rd_complete: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        rd_mis |=> rd_valid_r && addr_err_r)
        else $error("faulting read did not complete");
    a_out_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
        (rd_req && rd_ea > MEM_LAST && rd_ext_op == DSA_OP_NONE && !rd_byte)
        |=> rd_data_r == DATA_RST)
        else $error("outside read not zero");
    a_byte_low: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
        rd_req && rd_byte |=> rd_data_r[15:8] == 8'h00)
        else $error("byte read high byte not clear");
    a_ptr_step: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
        rd_req && rd_postinc && !rd_byte |=> rd_ptr_next_r == $past(rd_ptr) + STEP_WORD)
        else $error("word post-increment wrong");
    a_hold_high: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
        rd_req && rd_byte && rd_ext_op == DSA_OP_NONE
        |=> rd_wreg_r[15:8] == $past(rd_wreg_old[15:8]))
        else $error("byte load changed high byte");
    a_sign_ext: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
        rd_req && rd_ext_op == DSA_OP_SE |=> rd_wreg_r[15:8] == {8{rd_wreg_r[7]}})
        else $error("sign extend wrong");
    a_zero_ext: assert property (@(posedge clk_sys) disable iff (rst) // [RL14]
        rd_req && rd_ext_op == DSA_OP_ZE |=> rd_wreg_r[15:8] == 8'h00)
        else $error("zero extend wrong");
    a_lane_byte: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
        wr_req && wr_byte && wr_in |-> $onehot(wr_lane))
        else $error("byte write not single lane");

    c_misread: cover property (@(posedge clk_sys) rd_mis);
    c_miswrite: cover property (@(posedge clk_sys) wr_mis);
    c_byte_write: cover property (@(posedge clk_sys) wr_req && wr_byte && wr_ea[0]);
    c_sfr_read: cover property (@(posedge clk_sys) rd_req && rd_ea <= SFR_LAST);
endmodule
`default_nettype wire

// [dsa_sfr_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsa_sfr_model
    import dsa_pkg::*;
(
    // core side
    input wire logic clk_sys,
    input wire logic [ADDR_W-1:0] rd_ea,
    input wire logic sfr_wr_r,
    input wire logic [1:0] sfr_lane_r,
    input wire logic [ADDR_W-1:0] sfr_addr_r,
    input wire logic [DATA_W-1:0] sfr_wdata_r,
    // register data back
    output logic [DATA_W-1:0] sfr_rdata
);
    logic [DATA_W-1:0] regs [8] = '{default: 16'h0000};
    logic [DATA_W-1:0] junk = 16'hA5C3;
    // not selected: changing pattern, never a stale value
    always_comb
    begin
        if (rd_ea > SFR_LAST)
            sfr_rdata = junk;
        else if (rd_ea[15:4] == 12'h080)
            sfr_rdata = regs[rd_ea[3:1]];
        else
            sfr_rdata = 16'h0000;
    end
    always @(posedge clk_sys)
    begin
        junk <= ~junk ^ 16'h0101;
        if (sfr_wr_r && sfr_addr_r[15:4] == 12'h080)
        begin
            if (sfr_lane_r[0])
                regs[sfr_addr_r[3:1]][7:0] <= sfr_wdata_r[7:0];
            if (sfr_lane_r[1])
                regs[sfr_addr_r[3:1]][15:8] <= sfr_wdata_r[15:8];
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsa_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, rd_req = 1'b0, rd_byte = 1'b0, rd_near = 1'b0;
    logic wr_req = 1'b0, wr_byte = 1'b0, rd_page_we = 1'b0, wr_page_we = 1'b0;
    logic rd_postinc = 1'b1, wr_postinc = 1'b1;
    logic [15:0] rd_ptr = 16'h0000, wr_ptr = 16'h0000, wr_data = 16'h0000, rd_wreg_old = 16'h0000;
    logic [9:0] page_wdata = 10'h000, rpg = PAGE_RST, wpg = PAGE_RST;
    dsa_ext_t rd_ext_op = DSA_OP_NONE;
    logic rd_valid_r, wr_done_r, sfr_wr_r, addr_err_r;
    logic [15:0] rd_data_r, rd_wreg_r, rd_ptr_next_r, wr_ptr_next_r, sfr_addr_r, sfr_wdata_r;
    logic [15:0] sfr_rdata, o, a;
    logic [23:0] rd_ext_addr_r, wr_ext_addr_r;
    logic [9:0] read_page_register_r, write_page_register_r;
    logic [1:0] sfr_lane_r;
    logic [72:0] qr[$], qm[$], qw[$], ml;
    logic [15:0] r [8];
    logic [7:0] b0, b1;
    int mismatches = 0, check_count = 0, cyc = 0, s;
    wire logic [NEAR_W-1:0] rd_near_addr = rd_ptr[12:0];
    wire logic [15:0] rd_ea = rd_near ? {3'h0, rd_near_addr} : rd_ptr;
    dsa_unit u_dsa_unit (.*);
    dsa_sfr_model u_dsa_sfr_model (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic cmp(input logic [72:0] g, x);
        check_count++;
        if (g !== x)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // requests last one cycle; strobes drop by nba on the edge
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            rd_page_we <= 1'b0;
            wr_page_we <= 1'b0;
            @(negedge clk_sys);
        end
    endtask
    task automatic rd(input logic [15:0] p, input logic b, nr, input dsa_ext_t op,
                      input logic [15:0] d, w, input int n);
        logic e;
        e = !b && p[0];
        rd_req = 1'b1;
        rd_byte = b;
        rd_near = nr;
        rd_ext_op = op;
        rd_ptr = nr ? {3'h5, p[12:0]} : p;
        rd_wreg_old = o;
        qr.push_back({e, rpg[8:0], p[14:0], p + (b ? STEP_BYTE : STEP_WORD), w, d});
        qm.push_back({25'h1FFFFFF, {16{!nr}}, {32{!e}}});
        tick(n);
    endtask
    task automatic wr(input logic [15:0] p, input logic b, input logic [15:0] d, input int n);
        wr_req = 1'b1;
        wr_byte = b;
        wr_ptr = p;
        wr_data = d;
        qw.push_back({!b && p[0], wpg[8:0], p[14:0], p + (b ? STEP_BYTE : STEP_WORD)});
        tick(n);
    endtask
    always @(negedge clk_sys)
    begin
        if (rd_valid_r === 1'b1)
        begin
            ml = qm.pop_front();
            cmp({addr_err_r, rd_ext_addr_r, rd_ptr_next_r, rd_wreg_r, rd_data_r} & ml,
                qr.pop_front() & ml);
        end
        if (wr_done_r === 1'b1)
            cmp({addr_err_r, wr_ext_addr_r, wr_ptr_next_r}, qw.pop_front());
    end
    // whole run needs about 75 cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            complete_run;
        end
    end
    initial
    begin
        s = $urandom(61479);
        foreach (r[i])
            r[i] = $urandom;
        b0 = r[0][7:0] | 8'h80;
        b1 = r[1][15:8];
        o = r[2];
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        wr(16'h2000, 1'b0, r[3], 3);
        rd(16'h2000, 1'b0, 1'b0, DSA_OP_NONE, r[3], r[3], 1);
        wr(16'h2000, 1'b1, {b0, b0}, 1);
        wr(16'h2001, 1'b1, {b1, b1}, 3);
        rd(16'h2000, 1'b0, 1'b0, DSA_OP_NONE, {b1, b0}, {b1, b0}, 1);
        rd(16'h2001, 1'b1, 1'b0, DSA_OP_NONE, {8'h00, b1}, {o[15:8], b1}, 1);
        rd(16'h2000, 1'b1, 1'b0, DSA_OP_SE, {8'h00, b0}, {8'hFF, b0}, 1);
        rd(16'h2000, 1'b1, 1'b0, DSA_OP_ZE, {8'h00, b0}, {8'h00, b0}, 1);
        $display("test bytes done");
        wr(16'h2001, 1'b0, r[5], 3);
        rd(16'h2000, 1'b0, 1'b0, DSA_OP_NONE, {b1, b0}, {b1, b0}, 1);
        rd(16'h2003, 1'b0, 1'b0, DSA_OP_NONE, 16'h0000, 16'h0000, 1);
        $display("test faults done");
        wr(16'hCFFE, 1'b0, r[6], 1);
        wr(16'hD000, 1'b0, r[7], 3);
        rd(16'hCFFE, 1'b0, 1'b0, DSA_OP_NONE, r[6], r[6], 1);
        rd(16'hD000, 1'b0, 1'b0, DSA_OP_NONE, 16'h0000, 16'h0000, 1);
        rd(16'hFFFF, 1'b1, 1'b0, DSA_OP_NONE, 16'h0000, {o[15:8], 8'h00}, 1);
        $display("test range done");
        wr(16'h0804, 1'b0, r[0], 1);
        wr(16'h0805, 1'b0, r[1], 3);
        rd(16'h0804, 1'b0, 1'b0, DSA_OP_NONE, r[0], r[0], 1);
        rd(16'h0900, 1'b0, 1'b0, DSA_OP_NONE, 16'h0000, 16'h0000, 1);
        wr(16'h1FFE, 1'b0, r[2], 3);
        rd(16'h1FFE, 1'b0, 1'b1, DSA_OP_NONE, r[2], r[2], 1);
        $display("test sfr near done");
        rd_page_we = 1'b1;
        page_wdata = r[3][9:0];
        rpg = r[3][9:0];
        tick(1);
        wr_page_we = 1'b1;
        page_wdata = r[4][9:0];
        wpg = r[4][9:0];
        tick(1);
        cmp({read_page_register_r, write_page_register_r}, {rpg, wpg});
        for (int i = 0; i < 8; i++)
        begin
            a = 16'h4000 | (r[i] & 16'h0FFE);
            wr(a, 1'b0, r[i], 2);
            wr(a + 16'h4001, 1'b1, r[i], 0);
            rd(a, 1'b0, 1'b0, DSA_OP_NONE, r[i], r[i], 1);
        end
        tick(3);
        $display("test pages done");
        if (qr.size() != 0 || qw.size() != 0)
            mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
